/* shared/pec_pkg.sv */
// Constants for the pulse event counter: register offsets, reset values and function codes.
// Assumes a plain register port with word-wide data and one-cycle strobes.
`default_nettype none
package pec_pkg;
    // ------------------------------------------------------------------
    // Register offsets.
    // ------------------------------------------------------------------
    localparam logic [3:0] PEC_ADDR_FAST_TYPE = 4'h0;
    localparam logic [3:0] PEC_ADDR_IN1_FUNC = 4'h1;
    localparam logic [3:0] PEC_ADDR_IN2_FUNC = 4'h2;
    localparam logic [3:0] PEC_ADDR_IN3_FUNC = 4'h3;
    localparam logic [3:0] PEC_ADDR_IN4_FUNC = 4'h4;
    localparam logic [3:0] PEC_ADDR_FAST_FUNC = 4'h5;
    localparam logic [3:0] PEC_ADDR_TRANS_SEL = 4'h6;
    localparam logic [3:0] PEC_ADDR_RELAY1_SEL = 4'h7;
    localparam logic [3:0] PEC_ADDR_RELAY2_SEL = 4'h8;
    localparam logic [3:0] PEC_ADDR_TARGET = 4'h9;
    localparam logic [3:0] PEC_ADDR_MARKER = 4'hA;
    localparam logic [3:0] PEC_ADDR_COUNT = 4'hB;
    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [15:0] PEC_RST_FAST_TYPE = 16'h0000;
    localparam logic [15:0] PEC_RST_IN1_FUNC = 16'h0001;
    localparam logic [15:0] PEC_RST_IN2_FUNC = 16'h0004;
    localparam logic [15:0] PEC_RST_IN3_FUNC = 16'h0007;
    localparam logic [15:0] PEC_RST_IN4_FUNC = 16'h0000;
    localparam logic [15:0] PEC_RST_FAST_FUNC = 16'h0000;
    localparam logic [15:0] PEC_RST_TRANS_SEL = 16'h0000;
    localparam logic [15:0] PEC_RST_RELAY1_SEL = 16'h0001;
    localparam logic [15:0] PEC_RST_RELAY2_SEL = 16'h0005;
    localparam logic [15:0] PEC_RST_TARGET = 16'h0000;
    localparam logic [15:0] PEC_RST_MARKER = 16'h0000;
    localparam logic [15:0] PEC_RST_COUNT = 16'h0000;
    // ------------------------------------------------------------------
    // Function codes and field positions.
    // ------------------------------------------------------------------
    localparam logic [15:0] PEC_FUNC_CLEAR = 16'h001C;
    localparam logic [15:0] PEC_FUNC_TRIGGER = 16'h001F;
    localparam logic [15:0] PEC_OUT_TARGET_HIT = 16'h0012;
    localparam logic [15:0] PEC_OUT_MARKER_HIT = 16'h0013;
    localparam int PEC_FAST_TYPE_BIT = 0;
    localparam logic PEC_FAST_IS_PULSE = 1'b0;
    localparam logic PEC_FAST_IS_DIGITAL = 1'b1;
endpackage : pec_pkg
`default_nettype wire

/* verilog/pec_counter.sv */
// Pulse event counter: counts rising edges on selected inputs and flags reached values.
// Assumes inputs are asynchronous pins and the register master never issues both strobes.
// What this block does
// - Input coded 31 adds one per pulse.
// - Input coded 28 clears the count.
// - Fast input type 0 pulse, 1 digital.
// - Count restarts after reaching target value.
// - Output coded 18 on at target.
// - Output coded 19 on at marker.
// - Only inputs with code 31 count; the fast input counts only when its type is 1, digital.
`default_nettype none
module pec_counter (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic digital_input_1,
    input wire logic digital_input_2,
    input wire logic digital_input_3,
    input wire logic digital_input_4,
    input wire logic fast_pulse_input,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    output logic transistor_output,
    output logic relay_output_1,
    output logic relay_output_2
);
    import pec_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisers.
    // ------------------------------------------------------------------
    // Bit 4 is the fast input, bits 3..0 the ordinary inputs.
    logic [4:0] pins;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] prev;
    assign pins = {fast_pulse_input, digital_input_4, digital_input_3, digital_input_2, digital_input_1};

    // Two stages guard against metastability; prev feeds the edge detector.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
            prev <= 5'h00;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // ------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------
    logic [15:0] fast_input_type_select;
    logic [15:0] input1_function_select;
    logic [15:0] input2_function_select;
    logic [15:0] input3_function_select;
    logic [15:0] input4_function_select;
    logic [15:0] fast_input_function_select;
    logic [15:0] transistor_output_select;
    logic [15:0] relay1_output_select;
    logic [15:0] relay2_output_select;
    logic [15:0] count_target_value;
    logic [15:0] count_marker_value;
    logic [15:0] accumulated_count;
    logic [15:0] next_fast_type;
    logic [15:0] next_in1;
    logic [15:0] next_in2;
    logic [15:0] next_in3;
    logic [15:0] next_in4;
    logic [15:0] next_fast_func;
    logic [15:0] next_trans;
    logic [15:0] next_relay1;
    logic [15:0] next_relay2;
    logic [15:0] next_target;
    logic [15:0] next_marker;

    // Writes land on the addressed register; the count itself is read-only.
    always_comb begin
        next_fast_type = fast_input_type_select;
        next_in1 = input1_function_select;
        next_in2 = input2_function_select;
        next_in3 = input3_function_select;
        next_in4 = input4_function_select;
        next_fast_func = fast_input_function_select;
        next_trans = transistor_output_select;
        next_relay1 = relay1_output_select;
        next_relay2 = relay2_output_select;
        next_target = count_target_value;
        next_marker = count_marker_value;
        if (reg_write) begin
            case (reg_addr)
                PEC_ADDR_FAST_TYPE: begin
                    // Only one bit is meaningful for the type selector.
                    next_fast_type = {15'h0, reg_wdata[PEC_FAST_TYPE_BIT]};
                end
                PEC_ADDR_IN1_FUNC: next_in1 = reg_wdata;
                PEC_ADDR_IN2_FUNC: next_in2 = reg_wdata;
                PEC_ADDR_IN3_FUNC: next_in3 = reg_wdata;
                PEC_ADDR_IN4_FUNC: next_in4 = reg_wdata;
                PEC_ADDR_FAST_FUNC: next_fast_func = reg_wdata;
                PEC_ADDR_TRANS_SEL: next_trans = reg_wdata;
                PEC_ADDR_RELAY1_SEL: next_relay1 = reg_wdata;
                PEC_ADDR_RELAY2_SEL: next_relay2 = reg_wdata;
                PEC_ADDR_TARGET: begin
                    // keep marker at or below target
                    // Lowering the target below the marker pulls the marker down with it.
                    next_target = reg_wdata;
                    if (count_marker_value > reg_wdata) begin
                        next_marker = reg_wdata;
                    end
                end
                PEC_ADDR_MARKER: begin
                    next_marker = (reg_wdata > count_target_value) ? count_target_value : reg_wdata;
                end
                default: begin
                    // Unmapped or read-only addresses ignore writes.
                end
            endcase
        end
    end

    // Configuration registers take their documented reset values.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fast_input_type_select <= PEC_RST_FAST_TYPE;
            input1_function_select <= PEC_RST_IN1_FUNC;
            input2_function_select <= PEC_RST_IN2_FUNC;
            input3_function_select <= PEC_RST_IN3_FUNC;
            input4_function_select <= PEC_RST_IN4_FUNC;
            fast_input_function_select <= PEC_RST_FAST_FUNC;
            transistor_output_select <= PEC_RST_TRANS_SEL;
            relay1_output_select <= PEC_RST_RELAY1_SEL;
            relay2_output_select <= PEC_RST_RELAY2_SEL;
            count_target_value <= PEC_RST_TARGET;
            count_marker_value <= PEC_RST_MARKER;
        end else begin
            fast_input_type_select <= next_fast_type;
            input1_function_select <= next_in1;
            input2_function_select <= next_in2;
            input3_function_select <= next_in3;
            input4_function_select <= next_in4;
            fast_input_function_select <= next_fast_func;
            transistor_output_select <= next_trans;
            relay1_output_select <= next_relay1;
            relay2_output_select <= next_relay2;
            count_target_value <= next_target;
            count_marker_value <= next_marker;
        end
    end

    // ------------------------------------------------------------------
    // Input decoding.
    // ------------------------------------------------------------------
    logic [15:0] func_sel [5];
    logic [4:0] input_enabled;
    logic [4:0] trig_sel;
    logic [4:0] clr_sel;
    logic pulse_event;
    logic clear_event;
    assign func_sel[0] = input1_function_select;
    assign func_sel[1] = input2_function_select;
    assign func_sel[2] = input3_function_select;
    assign func_sel[3] = input4_function_select;
    assign func_sel[4] = fast_input_function_select;

    // relies on software setting digital mode first
    // The fast input only takes part when its type selects digital operation.
    assign input_enabled = {fast_input_type_select[PEC_FAST_TYPE_BIT] == PEC_FAST_IS_DIGITAL, 4'hF};

    // only coded inputs count
    // Each of the five inputs is decoded the same way.
    for (genvar i = 0; i < 5; i++) begin : g_dec
        assign trig_sel[i] = input_enabled[i] && (func_sel[i] == PEC_FUNC_TRIGGER);
        assign clr_sel[i] = input_enabled[i] && (func_sel[i] == PEC_FUNC_CLEAR);
    end

    // rising edge counts
    // A pulse is a rising edge; coincident edges on two inputs still count once.
    assign pulse_event = |(trig_sel & sync2 & ~prev);
    // clear level
    // Clearing is level sensitive: the count stays zero while the input is held.
    assign clear_event = |(clr_sel & sync2);

    // ------------------------------------------------------------------
    // Counter.
    // ------------------------------------------------------------------
    logic [15:0] next_count;

    // Clear outranks counting so a held clear always pins the count.
    always_comb begin
        next_count = accumulated_count;
        if (clear_event) begin
            next_count = 16'h0000;
        end else if (pulse_event) begin
            // restart at target
            // Reaching the target shows for one pulse, then the next pulse starts over at one.
            if (accumulated_count >= count_target_value) begin
                next_count = 16'h0001;
            end else begin
                next_count = accumulated_count + 16'h0001;
            end
        end
    end

    // The count register resets to zero.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            accumulated_count <= PEC_RST_COUNT;
        end else begin
            accumulated_count <= next_count;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    logic target_hit;
    logic marker_hit;
    logic next_trans_out;
    logic next_relay1_out;
    logic next_relay2_out;
    logic [15:0] next_rdata;
    assign target_hit = (accumulated_count == count_target_value);
    assign marker_hit = (accumulated_count == count_marker_value);

    // Maps one output selection code onto the two reached flags.
    function automatic logic pec_out_map(input logic [15:0] sel, input logic t_hit, input logic m_hit);
        logic r;
        r = 1'b0;
        if (sel == PEC_OUT_TARGET_HIT) begin
            r = t_hit;
        end
        if (sel == PEC_OUT_MARKER_HIT) begin
            r = m_hit;
        end
        return r;
    endfunction : pec_out_map

    // Output and read data next values.
    always_comb begin
        next_trans_out = pec_out_map(transistor_output_select, target_hit, marker_hit);
        next_relay1_out = pec_out_map(relay1_output_select, target_hit, marker_hit);
        next_relay2_out = pec_out_map(relay2_output_select, target_hit, marker_hit);
        next_rdata = 16'h0000;
        if (reg_read) begin
            case (reg_addr)
                PEC_ADDR_FAST_TYPE: next_rdata = fast_input_type_select;
                PEC_ADDR_IN1_FUNC: next_rdata = input1_function_select;
                PEC_ADDR_IN2_FUNC: next_rdata = input2_function_select;
                PEC_ADDR_IN3_FUNC: next_rdata = input3_function_select;
                PEC_ADDR_IN4_FUNC: next_rdata = input4_function_select;
                PEC_ADDR_FAST_FUNC: next_rdata = fast_input_function_select;
                PEC_ADDR_TRANS_SEL: next_rdata = transistor_output_select;
                PEC_ADDR_RELAY1_SEL: next_rdata = relay1_output_select;
                PEC_ADDR_RELAY2_SEL: next_rdata = relay2_output_select;
                PEC_ADDR_TARGET: next_rdata = count_target_value;
                PEC_ADDR_MARKER: next_rdata = count_marker_value;
                PEC_ADDR_COUNT: next_rdata = accumulated_count;
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    // Outputs are registered, so they lag the count by one cycle.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            transistor_output <= 1'b0;
            relay_output_1 <= 1'b0;
            relay_output_2 <= 1'b0;
            reg_rdata <= 16'h0000;
        end else begin
            transistor_output <= next_trans_out;
            relay_output_1 <= next_relay1_out;
            relay_output_2 <= next_relay2_out;
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    count_step_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (pulse_event && !clear_event && accumulated_count < count_target_value)
        |=> accumulated_count == $past(accumulated_count) + 16'h0001)
        else $error("count did not step on pulse");
    count_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        clear_event |=> accumulated_count == 16'h0000)
        else $error("count not cleared");
    fast_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fast_input_type_select[0] == PEC_FAST_IS_PULSE) |-> !trig_sel[4] && !clr_sel[4])
        else $error("fast input used in pulse mode");
    count_wrap_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (pulse_event && !clear_event && accumulated_count >= count_target_value)
        |=> accumulated_count == 16'h0001)
        else $error("count did not restart");
    target_out_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (relay1_output_select == PEC_OUT_TARGET_HIT && target_hit) |=> relay_output_1)
        else $error("relay 1 missed target");
    marker_out_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (transistor_output_select == PEC_OUT_MARKER_HIT) |=> transistor_output == $past(marker_hit))
        else $error("transistor output wrong for marker");
    count_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!pulse_event && !clear_event) |=> $stable(accumulated_count))
        else $error("count moved without cause");
    marker_bound_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        count_marker_value <= count_target_value)
        else $error("marker above target");
endmodule : pec_counter
`default_nettype wire

/* tb/pec_pulse_source.sv */
// Partner model: the switch-pulse source that feeds the five counter input pins.
// Assumes the bench asks for a pulse with a one-cycle request and keeps pulses apart.
`default_nettype none
module pec_pulse_source (
    input wire logic ref_clk,
    input wire logic [4:0] fire_mask,
    input wire logic [4:0] level_mask,
    output logic [4:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    // Two delay stages stretch each request into a two-cycle high pulse.
    logic [4:0] stage_a;
    logic [4:0] stage_b;
    // -----------------------------------------------------------------
    // Pulse shaping
    // -----------------------------------------------------------------
    // The stages only register, so a pin never glitches within a cycle.
    always_ff @(posedge ref_clk) begin
        stage_a <= fire_mask;
        stage_b <= stage_a;
    end
    // five count sources
    // Bits 0 to 3 are the digital inputs and bit 4 the fast input; a level mask holds a pin high.
    assign pins = stage_a | stage_b | level_mask;
    // The stages settle to zero two edges after start, well inside the bench's reset.
endmodule : pec_pulse_source
`default_nettype wire

/* tb/test_pec_counter.sv */
// Testbench: drives the register port and the pulse source, and checks counts and outputs.
// Assumes the register map and latencies of the pec_pkg package and the design hand-over.
`default_nettype none
module test_pec_counter;
    timeunit 1ns;
    timeprecision 1ns;
    import pec_pkg::*;
    // -----------------------------------------------------------------
    // Signals
    // -----------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic transistor_output;
    logic relay_output_1;
    logic relay_output_2;
    logic [4:0] fire_mask = 5'h0;
    logic [4:0] level_mask = 5'h0;
    logic [4:0] pins;
    logic [15:0] got;
    int n_fail = 0;
    int n_compared = 0;
    // Reset values in register index order.
    logic [15:0] rst_tab [0:11] = '{PEC_RST_FAST_TYPE, PEC_RST_IN1_FUNC, PEC_RST_IN2_FUNC,
        PEC_RST_IN3_FUNC, PEC_RST_IN4_FUNC, PEC_RST_FAST_FUNC, PEC_RST_TRANS_SEL,
        PEC_RST_RELAY1_SEL, PEC_RST_RELAY2_SEL, PEC_RST_TARGET, PEC_RST_MARKER, PEC_RST_COUNT};
    // The 25 MHz clock.
    always #20 ref_clk = ~ref_clk;
    pec_counter u_pec_counter (.ref_clk(ref_clk), .reset_n(reset_n),
        .digital_input_1(pins[0]), .digital_input_2(pins[1]), .digital_input_3(pins[2]),
        .digital_input_4(pins[3]), .fast_pulse_input(pins[4]), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .transistor_output(transistor_output), .relay_output_1(relay_output_1),
        .relay_output_2(relay_output_2));
    pec_pulse_source u_pec_pulse_source (.ref_clk(ref_clk), .fire_mask(fire_mask),
        .level_mask(level_mask), .pins(pins));
    // -----------------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------------
    // One-cycle write strobe.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask : wr
    // One-cycle read strobe; the data stand only in the following cycle, so sample there.
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1;
        got = reg_rdata;
    endtask : rd
    // Case-equality compare so an unknown never matches.
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Read a register and compare it.
    task automatic chk_reg(input logic [3:0] a, input logic [15:0] e);
        rd(a);
        chk(got, e);
    endtask : chk_reg
    // Every register against its reset value, in index order.
    task automatic chk_rst;
        for (int i = 0; i < 12; i++) begin
            chk_reg(i[3:0], rst_tab[i]);
        end
    endtask : chk_rst
    // Compare the three outputs packed as {transistor, relay1, relay2}.
    task automatic chk_out(input logic [2:0] e);
        chk({13'h0, transistor_output, relay_output_1, relay_output_2}, {13'h0, e});
    endtask : chk_out
    // One pulse, then enough cycles for sync, count and output stages to settle.
    task automatic pulse(input logic [4:0] m);
        @(posedge ref_clk);
        fire_mask <= m;
        @(posedge ref_clk);
        fire_mask <= 5'h0;
        repeat (8) @(posedge ref_clk);
    endtask : pulse
    // Verdict; the only place that ends the run.
    task automatic complete_run;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    // -----------------------------------------------------------------
    // Watchdog
    // -----------------------------------------------------------------
    // A hang counts as a mismatch.
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        complete_run();
    end
    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        // Reset values, an unmapped index and the read-only count.
        chk_rst();
        chk_reg(4'hC, 16'h0000);
        wr(PEC_ADDR_COUNT, 16'h1234);
        chk_reg(PEC_ADDR_COUNT, 16'h0000);
        chk_out(3'b000);
        // Input 1 counts, target 5 on the transistor, marker 3 on relay 1.
        wr(PEC_ADDR_IN1_FUNC, PEC_FUNC_TRIGGER);
        wr(PEC_ADDR_TARGET, 16'h0005);
        wr(PEC_ADDR_MARKER, 16'h0003);
        wr(PEC_ADDR_TRANS_SEL, PEC_OUT_TARGET_HIT);
        wr(PEC_ADDR_RELAY1_SEL, PEC_OUT_MARKER_HIT);
        wr(PEC_ADDR_RELAY2_SEL, 16'h0000);
        for (int k = 1; k <= 5; k++) begin
            pulse(5'h01);
            chk_reg(PEC_ADDR_COUNT, k[15:0]);
            chk_out({k == 5, k == 3, 1'b0});
        end
        pulse(5'h01);
        chk_reg(PEC_ADDR_COUNT, 16'h0001);
        chk_out(3'b000);
        // Inputs with other codes do not count.
        pulse(5'h0A);
        chk_reg(PEC_ADDR_COUNT, 16'h0001);
        // Fast input is ignored while it is a pulse-type input.
        wr(PEC_ADDR_FAST_FUNC, PEC_FUNC_TRIGGER);
        pulse(5'h10);
        chk_reg(PEC_ADDR_COUNT, 16'h0001);
        wr(PEC_ADDR_FAST_TYPE, 16'h0001);
        chk_reg(PEC_ADDR_FAST_TYPE, 16'h0001);
        pulse(5'h10);
        chk_reg(PEC_ADDR_COUNT, 16'h0002);
        // Input 3 clears; a pulse while clear is held still leaves zero.
        wr(PEC_ADDR_IN3_FUNC, PEC_FUNC_CLEAR);
        level_mask <= 5'h04;
        pulse(5'h01);
        chk_reg(PEC_ADDR_COUNT, 16'h0000);
        @(posedge ref_clk);
        level_mask <= 5'h00;
        pulse(5'h01);
        chk_reg(PEC_ADDR_COUNT, 16'h0001);
        // Marker is held at or below the target.
        wr(PEC_ADDR_MARKER, 16'h000A);
        chk_reg(PEC_ADDR_MARKER, 16'h0005);
        wr(PEC_ADDR_TARGET, 16'h0002);
        chk_reg(PEC_ADDR_MARKER, 16'h0002);
        chk_reg(PEC_ADDR_TARGET, 16'h0002);
        // Marker 2 on the transistor, target 4 on both relays; edges on two inputs count once.
        wr(PEC_ADDR_TARGET, 16'h0004);
        wr(PEC_ADDR_TRANS_SEL, PEC_OUT_MARKER_HIT);
        wr(PEC_ADDR_RELAY1_SEL, PEC_OUT_TARGET_HIT);
        wr(PEC_ADDR_RELAY2_SEL, PEC_OUT_TARGET_HIT);
        pulse(5'h11);
        chk_reg(PEC_ADDR_COUNT, 16'h0002);
        chk_out(3'b100);
        pulse(5'h01);
        chk_reg(PEC_ADDR_COUNT, 16'h0003);
        chk_out(3'b000);
        pulse(5'h01);
        chk_reg(PEC_ADDR_COUNT, 16'h0004);
        chk_out(3'b011);
        // A reset in mid-run restores every register and drops the outputs.
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        chk_rst();
        chk_out(3'b000);
        complete_run();
    end
endmodule : test_pec_counter
`default_nettype wire
